// File: hw/lrp_pkg.sv
// constants and types shared by the local register port design
package lrp_pkg;

   // -----------------------------------------------------------------
   // direct local port
   // -----------------------------------------------------------------
   localparam int          LRP_DW          = 8;
   localparam int          LRP_IDX_W       = 7;
   localparam int          LRP_NUM_CH      = 2;
   localparam int          LRP_NUM_IOR     = 2;
   localparam int          LRP_CH_STS_W    = 6;
   localparam int          LRP_SYNC_W      = 13;

   typedef enum logic [1:0] {
      LRP_SEL_DATA  = 2'h0,
      LRP_SEL_INDEX = 2'h1,
      LRP_SEL_STAT  = 2'h2,
      LRP_SEL_RSVD  = 2'h3
   } lrp_sel_t;

   localparam int          LRP_IDX_AUTOINC = 7;
   localparam logic [7:0]  LRP_INDEX_RST   = 8'h00;
   localparam logic [7:0]  LRP_STAT_RST    = 8'h00;
   localparam logic [7:0]  LRP_BYTE_RST    = 8'h00;
   localparam logic [6:0]  LRP_IDX_STEP    = 7'h01;

   // status/control bit positions
   localparam int          LRP_ST_DOORBELL = 7;
   localparam int          LRP_ST_CH1_INT  = 6;
   localparam int          LRP_ST_CH0_INT  = 5;
   localparam int          LRP_ST_INT_EN   = 4;
   localparam int          LRP_ST_LINE     = 3;
   localparam int          LRP_ST_PEEKPOKE = 2;
   localparam int          LRP_ST_BUSY1    = 1;
   localparam int          LRP_ST_BUSY0    = 0;

   // -----------------------------------------------------------------
   // internal file: channel window 40h..7fh, channel in index bit 5
   // -----------------------------------------------------------------
   localparam int          LRP_CH_WIN_BIT  = 6;
   localparam int          LRP_CH_SEL_BIT  = 5;
   localparam logic [4:0]  LRP_REL_BCNT    = 5'h00;
   localparam logic [4:0]  LRP_REL_BADDR   = 5'h03;
   localparam logic [4:0]  LRP_REL_CFG     = 5'h08;
   localparam logic [4:0]  LRP_REL_STROBE  = 5'h09;
   localparam logic [4:0]  LRP_REL_STS     = 5'h0a;
   localparam logic [4:0]  LRP_REL_TBI_B   = 5'h0c;
   localparam logic [4:0]  LRP_REL_CCNT    = 5'h10;
   localparam logic [4:0]  LRP_REL_CADDR   = 5'h13;
   localparam logic [4:0]  LRP_REL_TBI_C   = 5'h1c;
   localparam logic [4:0]  LRP_ADDR_BYTES  = 5'h04;
   localparam logic [4:0]  LRP_CNT_BYTES   = 5'h03;
   localparam logic [4:0]  LRP_TBI_BYTES   = 5'h02;
   // i/o decode at 38h..3bh: bit 1 picks control, bit 0 the range
   localparam logic [4:0]  LRP_IO_WIN      = 5'h0e;

   function automatic logic lrp_in_rng(input logic [4:0] rel, input logic [4:0] ofs, input logic [4:0] cnt);
      return (rel >= ofs) && (rel < ofs + cnt);
   endfunction : lrp_in_rng

   function automatic logic [1:0] lrp_bidx(input logic [4:0] rel, input logic [4:0] ofs);
      logic [4:0] d;
      d = rel - ofs;
      return d[1:0];
   endfunction : lrp_bidx

endpackage : lrp_pkg

// File: hw/lrp_reg_if.sv
// index/data path between the local port and the internal register file
`timescale 1ns/100ps
interface lrp_reg_if;
   logic [6:0] addr;
   logic       wr;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport port (output addr, output wr, output wdata, input rdata);
   modport file (input addr, input wr, input wdata, output rdata);
endinterface : lrp_reg_if

// File: hw/lrp_regfile.sv
// internal register file reached through index/data
`timescale 1ns/100ps
module lrp_regfile
   import lrp_pkg::*;
(
   input  wire logic                 sys_clk,
   input  wire logic                 rst_n,
   lrp_reg_if.file                   rf,
   input  wire logic [1:0][3:0][7:0] cur_addr_in,
   input  wire logic [1:0][2:0][7:0] cur_count_in,
   input  wire logic [1:0][1:0][7:0] tbi_cur_in,
   output      logic [1:0][3:0][7:0] base_addr_out,
   output      logic [1:0][2:0][7:0] base_count_out,
   output      logic [1:0][7:0]      chan_cfg_out,
   output      logic [1:0][5:0]      chan_status_out,
   output      logic [1:0][1:0][7:0] tbi_base_out,
   output      logic [1:0]           xfer_strobe,
   output      logic [1:0][7:0]      io_base_out,
   output      logic [1:0][7:0]      io_ctl_out
);
   import lrp_pkg::*;

   logic [4:0] rel;
   logic       ch;
   assign rel = rf.addr[4:0];
   assign ch  = rf.addr[LRP_CH_SEL_BIT];

   // -----------------------------------------------------------------
   // per-channel storage
   // -----------------------------------------------------------------
   for (genvar c = 0; c < LRP_NUM_CH; c++) begin : g_ch
      logic hit;
      logic [3:0][7:0] baddr_r;
      logic [2:0][7:0] bcnt_r;
      logic [7:0]      cfg_r;
      logic [5:0]      sts_r;
      logic [1:0][7:0] tbi_r;
      logic            stb_r;
      assign hit = rf.wr && rf.addr[LRP_CH_WIN_BIT] && (ch == 1'(c));
      always_ff @(posedge sys_clk) begin
         if (!rst_n) begin
            baddr_r <= '0;
            bcnt_r  <= '0;
            cfg_r   <= LRP_BYTE_RST;
            sts_r   <= '0;
            tbi_r   <= '0;
            stb_r   <= 1'b0;
         end else begin
            // strobe holds nothing: the write is only an event
            stb_r <= hit && (rel == LRP_REL_STROBE);
            if (hit) begin
               if (lrp_in_rng(rel, LRP_REL_BADDR, LRP_ADDR_BYTES))
                  baddr_r[lrp_bidx(rel, LRP_REL_BADDR)] <= rf.wdata;
               if (lrp_in_rng(rel, LRP_REL_BCNT, LRP_CNT_BYTES))
                  bcnt_r[lrp_bidx(rel, LRP_REL_BCNT)] <= rf.wdata;
               if (lrp_in_rng(rel, LRP_REL_TBI_B, LRP_TBI_BYTES))
                  tbi_r[lrp_bidx(rel, LRP_REL_TBI_B)] <= rf.wdata;
               if (rel == LRP_REL_CFG)
                  cfg_r <= rf.wdata;
               if (rel == LRP_REL_STS)
                  sts_r <= rf.wdata[LRP_CH_STS_W-1:0];
            end
         end
      end
      assign base_addr_out[c]   = baddr_r;
      assign base_count_out[c]  = bcnt_r;
      assign chan_cfg_out[c]    = cfg_r;
      assign chan_status_out[c] = sts_r;
      assign tbi_base_out[c]    = tbi_r;
      assign xfer_strobe[c]     = stb_r;
   end

   // -----------------------------------------------------------------
   // i/o decode ranges
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         io_base_out <= '0;
         io_ctl_out  <= '0;
      end else if (rf.wr && rf.addr[6:2] == LRP_IO_WIN) begin
         if (rf.addr[1])
            io_ctl_out[rf.addr[0]] <= rf.wdata;
         else
            io_base_out[rf.addr[0]] <= rf.wdata;
      end
   end

   // -----------------------------------------------------------------
   // read mux; holes and write-only slots read zero
   // -----------------------------------------------------------------
   always_comb begin
      rf.rdata = 8'h00;
      if (rf.addr[LRP_CH_WIN_BIT]) begin
         if (lrp_in_rng(rel, LRP_REL_BCNT, LRP_CNT_BYTES))
            rf.rdata = base_count_out[ch][lrp_bidx(rel, LRP_REL_BCNT)];
         else if (lrp_in_rng(rel, LRP_REL_BADDR, LRP_ADDR_BYTES))
            rf.rdata = base_addr_out[ch][lrp_bidx(rel, LRP_REL_BADDR)];
         else if (rel == LRP_REL_CFG)
            rf.rdata = chan_cfg_out[ch];
         else if (rel == LRP_REL_STS)
            rf.rdata = {2'h0, chan_status_out[ch]};
         else if (lrp_in_rng(rel, LRP_REL_TBI_B, LRP_TBI_BYTES))
            rf.rdata = tbi_base_out[ch][lrp_bidx(rel, LRP_REL_TBI_B)];
         else if (lrp_in_rng(rel, LRP_REL_CCNT, LRP_CNT_BYTES))
            rf.rdata = cur_count_in[ch][lrp_bidx(rel, LRP_REL_CCNT)];
         else if (lrp_in_rng(rel, LRP_REL_CADDR, LRP_ADDR_BYTES))
            rf.rdata = cur_addr_in[ch][lrp_bidx(rel, LRP_REL_CADDR)];
         else if (lrp_in_rng(rel, LRP_REL_TBI_C, LRP_TBI_BYTES))
            rf.rdata = tbi_cur_in[ch][lrp_bidx(rel, LRP_REL_TBI_C)];
      end else if (rf.addr[6:2] == LRP_IO_WIN) begin
         rf.rdata = rf.addr[1] ? io_ctl_out[rf.addr[0]] : io_base_out[rf.addr[0]];
      end
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   a_strobe_one_cycle: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (rf.wr && rf.addr[LRP_CH_WIN_BIT] && rel == LRP_REL_STROBE)
      |=> xfer_strobe[$past(ch)] ##1 !xfer_strobe[$past(ch, 2)])
      else $error("transfer strobe not a single pulse");

   a_sts_six_bits: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (rf.wr && rf.addr[LRP_CH_WIN_BIT] && rel == LRP_REL_STS)
      |=> chan_status_out[$past(ch)] == $past(rf.wdata[5:0]))
      else $error("channel status write lost");

endmodule : lrp_regfile

// File: hw/lrp_local_port.sv
// local processor register port: index, data and status/control
`timescale 1ns/100ps

// Contract
// - Index sits at local offset 1h, data register at 0h.
// - Status/control sits at local offset 2h, chosen by the select lines.
// - Index bits 6..0 select the internal register for data accesses.
// - Index holds the address of the register reached through data.
// - Index bit 7 set: index advances after every data read or write.
// - Reset clears the index, so auto-increment starts disabled.
// - Data reads return, and writes reach, the register the index selects.
// - Only status/control bit 4 is writable; other bits ignore writes.
// - Reset clears every status/control bit.
// - Bit 7 shows an enabled local doorbell interrupt pending; the code shows doorbell_pending whatever bit 4 holds.
// - Bits 6 and 5 show enabled channel 1 and 0 interrupts pending; the code shows chan_int_pending whatever bit 4 holds.
// - Bit 4 enables local interrupts; clear forces the interrupt line off.
// - Bit 3 shows the present state of the interrupt line.
// - Bit 2 shows whether the last peek/poke is still running.
// - Bits 1 and 0 show channel 1 and 0 base sets busy.
// - Each channel has base, current, strobe, configuration and status registers.
// - Base address is four writable bytes; current address four read-only bytes.
// - Base count is three writable bytes; current count three read-only bytes.
// - The transfer strobe register is write-only and stores nothing.
// - The channel status register is writable with six bits.
// - Buffer channels have two-byte base and read-only current addresses.
// - Two i/o decode ranges each have base and control bytes.
module lrp_local_port
   import lrp_pkg::*;
(
   input  wire logic                 sys_clk,
   input  wire logic                 rst_n,
   input  wire logic [1:0]           local_register_select_lines,
   input  wire logic                 lcl_cs_n,
   input  wire logic                 lcl_rd_n,
   input  wire logic                 lcl_wr_n,
   input  wire logic [7:0]           lcl_data_in,
   output      logic [7:0]           lcl_data_out,
   output      logic                 lcl_data_oe,
   input  wire logic                 doorbell_pending,
   input  wire logic [1:0]           chan_int_pending,
   input  wire logic                 peek_poke_busy,
   input  wire logic [1:0]           base_set_busy,
   output      logic                 board_interrupt_line,
   input  wire logic [1:0][3:0][7:0] cur_addr_in,
   input  wire logic [1:0][2:0][7:0] cur_count_in,
   input  wire logic [1:0][1:0][7:0] tbi_cur_in,
   output      logic [1:0][3:0][7:0] base_addr_out,
   output      logic [1:0][2:0][7:0] base_count_out,
   output      logic [1:0][7:0]      chan_cfg_out,
   output      logic [1:0][5:0]      chan_status_out,
   output      logic [1:0][1:0][7:0] tbi_base_out,
   output      logic [1:0]           xfer_strobe,
   output      logic [1:0][7:0]      io_base_out,
   output      logic [1:0][7:0]      io_ctl_out
);
   import lrp_pkg::*;

   // -----------------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------------
   // the local bus is asynchronous to sys_clk, so every pin passes two
   // flops; the cost is a few cycles of latency per access
   logic [LRP_SYNC_W-1:0] sync1_r;
   logic [LRP_SYNC_W-1:0] sync2_r;
   logic                  rd_n_d_r;
   logic                  wr_n_d_r;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sync1_r <= {LRP_SYNC_W{1'b1}};
         sync2_r <= {LRP_SYNC_W{1'b1}};
      end else begin
         sync1_r <= {local_register_select_lines, lcl_cs_n, lcl_rd_n, lcl_wr_n, lcl_data_in};
         sync2_r <= sync1_r;
      end
   end

   // edge detect looks at the second stage only
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rd_n_d_r <= 1'b1;
         wr_n_d_r <= 1'b1;
      end else begin
         rd_n_d_r <= sync2_r[9];
         wr_n_d_r <= sync2_r[8];
      end
   end

   lrp_sel_t   sel;
   logic       cs_s;
   logic       rd_s;
   logic       wr_s;
   logic [7:0] wdata_s;
   logic       rd_take;
   logic       wr_take;
   logic       data_acc;

   assign sel      = lrp_sel_t'(sync2_r[12:11]);
   assign cs_s     = !sync2_r[10];
   assign rd_s     = !sync2_r[9];
   assign wr_s     = !sync2_r[8];
   assign wdata_s  = sync2_r[7:0];
   // an access is taken once, on the leading edge of its strobe
   assign rd_take  = cs_s && rd_s && rd_n_d_r;
   assign wr_take  = cs_s && wr_s && wr_n_d_r;
   assign data_acc = (rd_take || wr_take) && (sel == LRP_SEL_DATA);

   // -----------------------------------------------------------------
   // index register
   // -----------------------------------------------------------------
   logic [7:0] index_r;
   logic [7:0] index_nxt;

   always_comb begin
      index_nxt = index_r;
      if (wr_take && sel == LRP_SEL_INDEX)
         index_nxt = wdata_s;
      else if (data_acc && index_r[LRP_IDX_AUTOINC])
         index_nxt = {index_r[LRP_IDX_AUTOINC], index_r[6:0] + LRP_IDX_STEP};
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n)
         index_r <= LRP_INDEX_RST;
      else
         index_r <= index_nxt;
   end

   // -----------------------------------------------------------------
   // internal register file through index/data
   // -----------------------------------------------------------------
   lrp_reg_if reg_bus ();

   assign reg_bus.addr  = index_r[LRP_IDX_W-1:0];
   assign reg_bus.wr    = wr_take && (sel == LRP_SEL_DATA);
   assign reg_bus.wdata = wdata_s;

   lrp_regfile u_regfile (
      .sys_clk         (sys_clk),
      .rst_n           (rst_n),
      .rf              (reg_bus.file),
      .cur_addr_in     (cur_addr_in),
      .cur_count_in    (cur_count_in),
      .tbi_cur_in      (tbi_cur_in),
      .base_addr_out   (base_addr_out),
      .base_count_out  (base_count_out),
      .chan_cfg_out    (chan_cfg_out),
      .chan_status_out (chan_status_out),
      .tbi_base_out    (tbi_base_out),
      .xfer_strobe     (xfer_strobe),
      .io_base_out     (io_base_out),
      .io_ctl_out      (io_ctl_out)
   );

   // -----------------------------------------------------------------
   // status/control and interrupt line
   // -----------------------------------------------------------------
   logic int_en_r;
   logic line_r;
   logic [7:0] stat_r;

   // only the enable bit takes writes; the rest are live status
   always_ff @(posedge sys_clk) begin
      if (!rst_n)
         int_en_r <= LRP_STAT_RST[LRP_ST_INT_EN];
      else if (wr_take && sel == LRP_SEL_STAT)
         int_en_r <= wdata_s[LRP_ST_INT_EN];
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n)
         line_r <= 1'b0;
      else
         line_r <= int_en_r && (doorbell_pending || (|chan_int_pending));
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         stat_r <= LRP_STAT_RST;
      end else begin
         stat_r[LRP_ST_DOORBELL] <= doorbell_pending;
         stat_r[LRP_ST_CH1_INT]  <= chan_int_pending[1];
         stat_r[LRP_ST_CH0_INT]  <= chan_int_pending[0];
         stat_r[LRP_ST_INT_EN]   <= int_en_r_next();
         stat_r[LRP_ST_LINE]     <= line_r;
         stat_r[LRP_ST_PEEKPOKE] <= peek_poke_busy;
         stat_r[LRP_ST_BUSY1]    <= base_set_busy[1];
         stat_r[LRP_ST_BUSY0]    <= base_set_busy[0];
      end
   end

   function automatic logic int_en_r_next();
      return int_en_r;
   endfunction : int_en_r_next

   assign board_interrupt_line = line_r;

   // -----------------------------------------------------------------
   // local data bus read side
   // -----------------------------------------------------------------
   logic [7:0] rd_mux;

   always_comb begin
      unique case (sel)
         LRP_SEL_DATA:  rd_mux = reg_bus.rdata;
         LRP_SEL_INDEX: rd_mux = index_r;
         LRP_SEL_STAT:  rd_mux = stat_r;
         LRP_SEL_RSVD:  rd_mux = 8'h00;
      endcase
   end

   // data is captured at the strobe edge so a later index step cannot
   // change what the processor sees mid-read
   always_ff @(posedge sys_clk) begin
      if (!rst_n)
         lcl_data_out <= 8'h00;
      else if (rd_take)
         lcl_data_out <= rd_mux;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n)
         lcl_data_oe <= 1'b0;
      else
         lcl_data_oe <= cs_s && rd_s;
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   a_index_reset_zero: assert property (@(posedge sys_clk)
      !rst_n |=> index_r == LRP_INDEX_RST)
      else $error("index not cleared by reset");

   a_stat_reset_zero: assert property (@(posedge sys_clk)
      !rst_n |=> stat_r == LRP_STAT_RST && !board_interrupt_line)
      else $error("status/control not cleared by reset");

   a_autoinc_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (data_acc && index_r[LRP_IDX_AUTOINC])
      |=> index_r[6:0] == $past(index_r[6:0]) + LRP_IDX_STEP && index_r[LRP_IDX_AUTOINC])
      else $error("index did not advance by one");

   a_index_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (data_acc && !index_r[LRP_IDX_AUTOINC]) |=> $stable(index_r))
      else $error("index moved without auto-increment");

   a_data_read_path: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (rd_take && sel == LRP_SEL_DATA) |=> lcl_data_out == $past(reg_bus.rdata))
      else $error("data read did not return selected register");

   a_data_write_path: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (wr_take && sel == LRP_SEL_DATA) |-> reg_bus.wr && reg_bus.addr == index_r[6:0])
      else $error("data write not sent to indexed register");

   a_enable_write_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !(wr_take && sel == LRP_SEL_STAT) |=> $stable(int_en_r))
      else $error("interrupt enable changed without a write");

   a_line_gated: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !int_en_r |=> !board_interrupt_line)
      else $error("interrupt line active while disabled");

   a_line_reflected: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ##1 stat_r[LRP_ST_LINE] == $past(board_interrupt_line))
      else $error("status bit 3 does not follow interrupt line");

   a_status_sources: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ##1 stat_r[LRP_ST_DOORBELL] == $past(doorbell_pending)
      && stat_r[LRP_ST_CH1_INT] == $past(chan_int_pending[1])
      && stat_r[LRP_ST_BUSY0] == $past(base_set_busy[0])
      && stat_r[LRP_ST_PEEKPOKE] == $past(peek_poke_busy))
      else $error("status bits do not track their sources");

   a_status_rest: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ##1 stat_r[LRP_ST_CH0_INT] == $past(chan_int_pending[0])
      && stat_r[LRP_ST_BUSY1] == $past(base_set_busy[1])
      && stat_r[LRP_ST_INT_EN] == $past(int_en_r))
      else $error("remaining status bits do not track their sources");

   // a strobe held low must count once, or auto-increment would skip
   a_take_once: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (rd_take || wr_take) |=> !(rd_take || wr_take))
      else $error("one strobe taken more than once");

   a_index_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (wr_take && sel == LRP_SEL_INDEX) |=> index_r == $past(wdata_s))
      else $error("index write lost");

   a_index_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (rd_take && sel == LRP_SEL_INDEX) |=> lcl_data_out == $past(index_r))
      else $error("index read returned wrong value");

   a_stat_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (rd_take && sel == LRP_SEL_STAT) |=> lcl_data_out == $past(stat_r))
      else $error("status read returned wrong value");

   a_rsvd_read_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (rd_take && sel == LRP_SEL_RSVD) |=> lcl_data_out == LRP_BYTE_RST)
      else $error("reserved offset did not read zero");

   a_enable_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (wr_take && sel == LRP_SEL_STAT) |=> int_en_r == $past(wdata_s[LRP_ST_INT_EN]))
      else $error("interrupt enable write lost");

   a_line_raise: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (int_en_r && doorbell_pending) |=> board_interrupt_line)
      else $error("enabled doorbell did not raise interrupt line");

   // read data must stand until the next read is taken
   a_data_out_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !rd_take |=> $stable(lcl_data_out))
      else $error("read data changed without a read");

   a_oe_drop: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (lcl_data_oe && !(cs_s && rd_s)) |=> !lcl_data_oe)
      else $error("data output enable stayed high after the read");

endmodule : lrp_local_port

// File: testbench/lrp_cpu_model.sv
// local processor model driving the register port strobes
`timescale 1ns/100ps
module lrp_cpu_model (
   input  wire logic       sys_clk,
   output      logic [1:0] sel,
   output      logic       cs_n,
   output      logic       rd_n,
   output      logic       wr_n,
   output      logic [7:0] wdata,
   input  wire logic [7:0] rdata
);
   initial begin
      sel = 2'h0;
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      wdata = 8'h00;
   end

   // -----------------------------------------------------------------
   // one access: address and data settle a cycle ahead of the strobe
   // -----------------------------------------------------------------
   task acc(input logic [1:0] s, input logic w, input logic [7:0] d, output logic [7:0] q);
      @(posedge sys_clk);
      sel <= s;
      wdata <= d;
      @(posedge sys_clk);
      cs_n <= 1'b0;
      rd_n <= w;
      wr_n <= !w;
      repeat (4) @(posedge sys_clk);
      q = rdata;
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      // released lines must not keep the old value
      wdata <= ~d;
      sel <= ~s;
      repeat (3) @(posedge sys_clk);
   endtask : acc
endmodule : lrp_cpu_model

// File: testbench/lrp_local_port_bench.sv
// self-checking bench for the local register port
`timescale 1ns/100ps
module lrp_local_port_bench;
   logic                 sys_clk, rst_n, cs_n, rd_n, wr_n, oe, db, pp, line;
   logic [1:0]           sel, ci, bb, stb;
   logic [7:0]           din, dout, q;
   logic [1:0][3:0][7:0] cura, basea;
   logic [1:0][2:0][7:0] basec, curc;
   logic [1:0][7:0]      cfg, iob, ioc;
   logic [1:0][5:0]      csts;
   logic [1:0][1:0][7:0] tbib, tbic;
   int                   num_errors, n_checks, cyc, n_stb, n_stb0, n_oe;

   lrp_cpu_model cpu (.sys_clk(sys_clk), .sel(sel), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
      .wdata(din), .rdata(dout));

   lrp_local_port uut (.sys_clk(sys_clk), .rst_n(rst_n), .local_register_select_lines(sel),
      .lcl_cs_n(cs_n), .lcl_rd_n(rd_n), .lcl_wr_n(wr_n), .lcl_data_in(din), .lcl_data_out(dout),
      .lcl_data_oe(oe), .doorbell_pending(db), .chan_int_pending(ci), .peek_poke_busy(pp),
      .base_set_busy(bb), .board_interrupt_line(line), .cur_addr_in(cura),
      .cur_count_in(curc), .tbi_cur_in(tbic), .base_addr_out(basea), .base_count_out(basec),
      .chan_cfg_out(cfg), .chan_status_out(csts), .tbi_base_out(tbib), .xfer_strobe(stb),
      .io_base_out(iob), .io_ctl_out(ioc));

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // hang guard: the whole run needs well under 2000 cycles
   always @(posedge sys_clk) begin
      cyc++;
      if (stb[1] === 1'b1) n_stb++;
      if (stb[0] === 1'b1) n_stb0++;
      if (oe === 1'b1) n_oe++;
      if (cyc == 5000) begin
         num_errors++;
         print_verdict();
      end
   end

   // -----------------------------------------------------------------
   // shared helpers
   // -----------------------------------------------------------------
   task print_verdict();
      $display("errors %0d checks %0d", num_errors, n_checks);
      if (num_errors == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : print_verdict

   task chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %0t got %h expected %h", $time, g, e);
      end
   endtask : chk

   task wr(input logic [1:0] s, input logic [7:0] d);
      cpu.acc(s, 1'b1, d, q);
   endtask : wr

   task rd(input logic [1:0] s, input logic [7:0] e);
      cpu.acc(s, 1'b0, 8'h00, q);
      // judge off the edge so the last enable count has landed
      @(negedge sys_clk);
      chk(q, e);
      chk(n_oe, 32'd4);
      n_oe = 0;
   endtask : rd

   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task t_reset();
      rd(2'h1, 8'h00);
      rd(2'h2, 8'h00);
      rd(2'h3, 8'h00);
   endtask : t_reset

   task t_index();
      wr(2'h1, 8'h48);
      wr(2'h0, 8'ha5);
      rd(2'h0, 8'ha5);
      chk(cfg[0], 8'ha5);
      rd(2'h1, 8'h48);
   endtask : t_index

   task t_autoinc();
      wr(2'h1, 8'hc3);
      for (int i = 0; i < 4; i++) wr(2'h0, 8'(8'h11 * (i + 1)));
      rd(2'h1, 8'hc7);
      chk(basea[0], 32'h44332211);
      wr(2'h1, 8'hf3);
      rd(2'h0, 8'ha1);
      wr(2'h0, 8'h00);
      rd(2'h0, 8'hc3);
      wr(2'h1, 8'hff);
      rd(2'h0, 8'h00);
      rd(2'h1, 8'h80);
   endtask : t_autoinc

   task t_status();
      wr(2'h2, 8'hff);
      rd(2'h2, 8'h10);
      @(posedge sys_clk);
      db <= 1'b1;
      ci <= 2'h3;
      pp <= 1'b1;
      bb <= 2'h3;
      wr(2'h2, 8'hff);
      rd(2'h2, 8'hff);
      chk(line, 1'b1);
      wr(2'h2, 8'h00);
      rd(2'h2, 8'he7);
      chk(line, 1'b0);
      @(posedge sys_clk);
      db <= 1'b0;
      ci <= 2'h0;
      pp <= 1'b0;
      bb <= 2'h0;
      rd(2'h2, 8'h00);
   endtask : t_status

   task t_chan();
      wr(2'h1, 8'h69);
      n_stb = 0;
      wr(2'h0, 8'h5a);
      chk(n_stb, 1);
      rd(2'h0, 8'h00);
      wr(2'h1, 8'hea);
      wr(2'h0, 8'hff);
      wr(2'h0, 8'h00);
      wr(2'h0, 8'h77);
      chk(csts[1], 6'h3f);
      chk(tbib[1][0], 8'h77);
      wr(2'h1, 8'hea);
      rd(2'h0, 8'h3f);
      rd(2'h0, 8'h00);
      rd(2'h0, 8'h77);
      wr(2'h1, 8'hb8);
      for (int i = 0; i < 4; i++) wr(2'h0, 8'(8'h50 + i));
      chk({ioc, iob}, 32'h53525150);
      wr(2'h1, 8'hc0);
      for (int i = 0; i < 3; i++) wr(2'h0, 8'(i + 1));
      chk(basec[0], 32'h00030201);
      wr(2'h1, 8'h49);
      n_stb0 = 0;
      wr(2'h0, 8'h00);
      chk(n_stb0, 1);
      wr(2'h1, 8'hd1);
      rd(2'h0, 8'h0b);
      rd(2'h0, 8'h0c);
      wr(2'h1, 8'hfd);
      rd(2'h0, 8'h9e);
   endtask : t_chan

   task t_rerun();
      wr(2'h2, 8'hff);
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(2'h1, 8'h00);
      rd(2'h2, 8'h00);
      chk(cfg[0], 32'h0);
   endtask : t_rerun

   initial begin
      rst_n = 1'b0;
      db = 1'b0;
      pp = 1'b0;
      ci = 2'h0;
      bb = 2'h0;
      cura = '0;
      cura[1] = 32'hd4c3b2a1;
      curc = '0;
      curc[0] = 24'h0c0b0a;
      tbic = '0;
      tbic[1] = 16'h9e8d;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_reset();
      t_index();
      t_autoinc();
      t_status();
      t_chan();
      t_rerun();
      print_verdict();
   end
endmodule : lrp_local_port_bench
